// [rtcr_cfg.svh]
// Offsets, field positions, reset values and counts of the clock-calendar register layer
`ifndef RTCR_CFG_SVH
`define RTCR_CFG_SVH
`define RTCR_OFS_CFG1 8'h00
`define RTCR_OFS_CAL 8'h04
`define RTCR_OFS_CFG2 8'h08
`define RTCR_OFS_ALCFG 8'h0c
`define RTCR_OFS_ALARM_REPEAT_COUNTER 8'h10
`define RTCR_OFS_TWH 8'h14
`define RTCR_OFS_TWL 8'h18
`define RTCR_OFS_AWH 8'h1c
`define RTCR_OFS_AWL 8'h20
`define RTCR_OFS_KEY 8'h24
`define RTCR_B_EN 7
`define RTCR_B_WREN 5
`define RTCR_B_SYNC 4
`define RTCR_B_HALF 3
`define RTCR_B_OE 2
`define RTCR_B_PWEN 7
`define RTCR_B_PWPOL 6
`define RTCR_B_CPRE 5
`define RTCR_B_SPRE 4
`define RTCR_B_AEN 7
`define RTCR_B_CHIME 6
`define RTCR_KEY1 8'h55
`define RTCR_KEY2 8'haa
`define RTCR_RST_CFG 8'h00
`define RTCR_RST_ONE 8'h01
`define RTCR_TICKS_XTAL 16'h4000
`define RTCR_TICKS_50HZ 16'h0019
`define RTCR_TICKS_60HZ 16'h001e
`define RTCR_SYNC_LEAD 16'h0008
`define RTCR_PWC_STAB 16'h0010
`define RTCR_PWC_SAMP 16'h0008
`endif

// [rtcr_pkg.sv]
// Types shared by the clock-calendar register layer
package rtcr_pkg;
	typedef enum logic [1:0] {
		RTCR_SRC_XTAL,
		RTCR_SRC_INTERNAL_OSCILLATOR,
		RTCR_SRC_50HZ,
		RTCR_SRC_60HZ
	} rtcr_src_type;
	typedef enum {
		RTCR_UL_IDLE,
		RTCR_UL_KEY1,
		RTCR_UL_ARMED
	} rtcr_unlock_type;
	typedef logic [7:0] rtcr_byte_type;
endpackage : rtcr_pkg

// [rtcr_winptr.sv]
// Two-bit value window pointer that steps down after each high-window access until it reaches zero
module rtcr_winptr (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic load,
	input wire logic [1:0] load_val,
	input wire logic hi_access,
	// State
	output logic [1:0] ptr_q
);
	always_ff @(posedge mclk) begin
		if (rst) begin
			ptr_q <= 2'h0;
		end else if (load) begin
			ptr_q <= load_val;
		end else if (hi_access && ptr_q != 2'h0) begin
			ptr_q <= ptr_q - 2'h1;
		end
	end
endmodule : rtcr_winptr

// [rtcr_top.sv]
// APB register layer, timebase and alarm of the BCD clock-calendar
`include "rtcr_cfg.svh"

// What this block does
// - Enable bit starts and stops timekeeping
// - Time value windows and config two need write-enable
// - Write-enable changes only after unlock sequence
// - Module enable writable only when write-enabled
// - Sync flag warns of rollover; software reads twice
// - Half-second flag, cleared by seconds write
// - Output enable gates the output pin
// - Time pointer decrements on high access, stops
// - Time pointer selects fields of both windows
// - Pointer 11 high window reads zero
// - Signed calibration adjusts four pulses per count
// - Source select picks timekeeping clock
// - Output select routes signal to pin
// - Power control enable, polarity and prescalers
// - Alarm enable self-clears at count zero, no chime
// - Chime wraps repeat counter, else stops
// - Repeat counter decrements each alarm event
// - Mask chooses alarm match interval
// - Alarm pointer decrements, selects alarm fields
// - Date values held as BCD digits
module rtcr_top #(
	parameter logic [15:0] TICKS_XTAL = `RTCR_TICKS_XTAL,
	parameter logic [15:0] TICKS_50HZ = `RTCR_TICKS_50HZ,
	parameter logic [15:0] TICKS_60HZ = `RTCR_TICKS_60HZ
) (
	// Clock and resets
	input wire logic mclk,
	input wire logic rst,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timebase pins, one per source
	input wire logic [3:0] src_pins,
	// Output pin
	output logic rtc_pin_q,
	output logic rtc_pin_oe_q
);
	import rtcr_pkg::*;

	rtcr_byte_type cfg1_q, cal_q, cfg2_q, alcfg_q, alarm_repeat_counter_q;
	rtcr_byte_type sec_q, min_q, hr_q, wd_q, day_q, mth_q, yr_q;
	rtcr_byte_type asec_q, amin_q, ahr_q, awd_q, aday_q, amth_q;
	rtcr_unlock_type ul_q;
	logic [3:0] s1_q, s2_q, s3_q;
	logic [15:0] hcnt_q, pwc_q;
	logic half_q, sync_q, apulse_q, pready_q, slverr_q;
	logic [31:0] rdata_q;
	logic [1:0] tptr, aptr;
	logic acc, wr, rd, wren, tick, lastq, half_end, sec_end, ev;
	logic [15:0] base, lim;
	logic amatch;
	rtcr_byte_type mday, rbyte, wb;

	assign prdata = rdata_q;
	assign pready = pready_q;
	assign pslverr = slverr_q;
	assign acc = psel && penable && pready_q;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign wb = pwdata[7:0];
	assign wren = cfg1_q[`RTCR_B_WREN];

	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] mx,
		input logic [7:0] mn);
		if (v >= mx) begin
			bcd_inc = mn;
		end else if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = v + 8'h01;
		end
	endfunction : bcd_inc

	rtcr_winptr u_tptr (
		.mclk(mclk),
		.rst(rst),
		.load(wr && paddr == `RTCR_OFS_CFG1),
		.load_val(wb[1:0]),
		.hi_access(acc && paddr == `RTCR_OFS_TWH),
		.ptr_q(tptr)
	);
	rtcr_winptr u_aptr (
		.mclk(mclk),
		.rst(rst || sys_rst),
		.load(wr && paddr == `RTCR_OFS_ALCFG),
		.load_val(wb[1:0]),
		.hi_access(acc && paddr == `RTCR_OFS_AWH),
		.ptr_q(aptr)
	);

	// Source pins are asynchronous; edge detect reads stages two and three only
	always_ff @(posedge mclk) begin
		s1_q <= src_pins;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end

	always_comb begin
		unique case (rtcr_src_type'(cfg2_q[3:2]))
			RTCR_SRC_60HZ: base = TICKS_60HZ;
			RTCR_SRC_50HZ: base = TICKS_50HZ;
			RTCR_SRC_INTERNAL_OSCILLATOR: base = TICKS_XTAL;
			RTCR_SRC_XTAL: base = TICKS_XTAL;
		endcase
		tick = s2_q[cfg2_q[3:2]] && !s3_q[cfg2_q[3:2]];
		// First half second of each minute is stretched or shrunk by four pulses per count
		if (sec_q == 8'h00 && !half_q) begin
			lim = base - {{6{cal_q[7]}}, cal_q, 2'b00};
		end else begin
			lim = base;
		end
	end

	assign lastq = hcnt_q + 16'h0001 >= lim;
	assign half_end = cfg1_q[`RTCR_B_EN] && tick && lastq;
	assign sec_end = half_end && half_q;

	// Day limit follows month and leap year
	always_comb begin
		unique case (mth_q)
			8'h02: mday = ((!yr_q[4] && (yr_q[3:0] == 4'h0 || yr_q[3:0] == 4'h4 ||
				yr_q[3:0] == 4'h8)) || (yr_q[4] && (yr_q[3:0] == 4'h2 ||
				yr_q[3:0] == 4'h6))) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: mday = 8'h30;
			default: mday = 8'h31;
		endcase
	end

	// Interval match on BCD fields; the leap day matches only when it exists
	always_comb begin
		unique case (alcfg_q[5:2])
			4'h0: amatch = 1'b1;
			4'h1: amatch = half_q;
			4'h2: amatch = half_q && sec_q[3:0] == asec_q[3:0];
			4'h3: amatch = half_q && sec_q == asec_q;
			4'h4: amatch = half_q && sec_q == asec_q && min_q[3:0] == amin_q[3:0];
			4'h5: amatch = half_q && sec_q == asec_q && min_q == amin_q;
			4'h6: amatch = half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q;
			4'h7: amatch = half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q &&
				wd_q == awd_q;
			4'h8: amatch = half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q &&
				day_q == aday_q;
			4'h9: amatch = half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q &&
				day_q == aday_q && mth_q == amth_q;
			default: amatch = 1'b0;
		endcase
	end
	assign ev = half_end && amatch && alcfg_q[`RTCR_B_AEN];

	// Half-second counter and flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			hcnt_q <= 16'h0000;
			half_q <= 1'b0;
		end else if (wr && paddr == `RTCR_OFS_TWL && tptr == 2'h0 && wren) begin
			hcnt_q <= 16'h0000;
			half_q <= 1'b0;
		end else if (half_end) begin
			hcnt_q <= 16'h0000;
			half_q <= !half_q;
		end else if (cfg1_q[`RTCR_B_EN] && tick) begin
			hcnt_q <= hcnt_q + 16'h0001;
		end
	end

	// Flag raised in the last ticks before a half-second ripple
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_q <= 1'b0;
		end else begin
			sync_q <= cfg1_q[`RTCR_B_EN] && hcnt_q + `RTCR_SYNC_LEAD >= lim;
		end
	end

	// Calendar values; a user write in the same cycle as a ripple wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			sec_q <= `RTCR_RST_CFG;
			min_q <= `RTCR_RST_CFG;
			hr_q <= `RTCR_RST_CFG;
			wd_q <= `RTCR_RST_CFG;
			day_q <= `RTCR_RST_ONE;
			mth_q <= `RTCR_RST_ONE;
			yr_q <= `RTCR_RST_CFG;
		end else if (wr && wren && paddr == `RTCR_OFS_TWH) begin
			unique case (tptr)
				2'h0: min_q <= {1'b0, wb[6:0]};
				2'h1: wd_q <= {5'h00, wb[2:0]};
				2'h2: mth_q <= {3'h0, wb[4:0]};
				2'h3: ;
			endcase
		end else if (wr && wren && paddr == `RTCR_OFS_TWL) begin
			unique case (tptr)
				2'h0: sec_q <= {1'b0, wb[6:0]};
				2'h1: hr_q <= {2'h0, wb[5:0]};
				2'h2: day_q <= {2'h0, wb[5:0]};
				2'h3: yr_q <= wb;
			endcase
		end else if (sec_end) begin
			sec_q <= bcd_inc(sec_q, 8'h59, 8'h00);
			if (sec_q == 8'h59) begin
				min_q <= bcd_inc(min_q, 8'h59, 8'h00) ;
				if (min_q == 8'h59) begin
					hr_q <= bcd_inc(hr_q, 8'h23, 8'h00) ;
					if (hr_q == 8'h23) begin
						wd_q <= (wd_q >= 8'h06) ? 8'h00 : wd_q + 8'h01;
						day_q <= bcd_inc(day_q, mday, 8'h01) ;
						if (day_q >= mday) begin
							mth_q <= bcd_inc(mth_q, 8'h12, 8'h01) ;
							if (mth_q >= 8'h12) begin
								yr_q <= bcd_inc(yr_q, 8'h99, 8'h00) ;
							end
						end
					end
				end
			end
		end
	end

	// Alarm values, reached through the alarm pointer
	always_ff @(posedge mclk) begin
		if (rst) begin
			asec_q <= `RTCR_RST_CFG;
			amin_q <= `RTCR_RST_CFG;
			ahr_q <= `RTCR_RST_CFG;
			awd_q <= `RTCR_RST_CFG;
			aday_q <= `RTCR_RST_ONE;
			amth_q <= `RTCR_RST_ONE;
		end else if (wr && paddr == `RTCR_OFS_AWH) begin
			unique case (aptr)
				2'h0: amin_q <= {1'b0, wb[6:0]};
				2'h1: awd_q <= {5'h00, wb[2:0]};
				2'h2: amth_q <= {3'h0, wb[4:0]};
				2'h3: ;
			endcase
		end else if (wr && paddr == `RTCR_OFS_AWL) begin
			unique case (aptr)
				2'h0: asec_q <= {1'b0, wb[6:0]};
				2'h1: ahr_q <= {2'h0, wb[5:0]};
				2'h2: aday_q <= {2'h0, wb[5:0]};
				2'h3: ;
			endcase
		end
	end

	// Unlock sequence: two key writes arm one write of config one
	always_ff @(posedge mclk) begin
		if (rst || sys_rst) begin
			ul_q <= RTCR_UL_IDLE;
		end else if (wr) begin
			unique case (ul_q)
				RTCR_UL_IDLE: ul_q <= (paddr == `RTCR_OFS_KEY && wb == `RTCR_KEY1) ?
					RTCR_UL_KEY1 : RTCR_UL_IDLE;
				RTCR_UL_KEY1: ul_q <= (paddr == `RTCR_OFS_KEY && wb == `RTCR_KEY2) ?
					RTCR_UL_ARMED : RTCR_UL_IDLE;
				RTCR_UL_ARMED: ul_q <= RTCR_UL_IDLE;
			endcase
		end
	end

	// Config registers: power-on reset only
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg1_q <= `RTCR_RST_CFG;
			cfg2_q <= `RTCR_RST_CFG;
			cal_q <= `RTCR_RST_CFG;
		end else if (wr) begin
			if (paddr == `RTCR_OFS_CFG1) begin
				cfg1_q[`RTCR_B_OE] <= wb[`RTCR_B_OE];
				if (wren) begin
					cfg1_q[`RTCR_B_EN] <= wb[`RTCR_B_EN];
				end
				if (ul_q == RTCR_UL_ARMED) begin
					cfg1_q[`RTCR_B_WREN] <= wb[`RTCR_B_WREN];
				end
			end
			if (paddr == `RTCR_OFS_CFG2 && wren) begin
				cfg2_q <= wb;
			end
			if (paddr == `RTCR_OFS_CAL) begin
				cal_q <= wb;
			end
		end
	end

	// Alarm config and repeat counter; a software write beats the self-clear
	always_ff @(posedge mclk) begin
		if (rst || sys_rst) begin
			alcfg_q <= `RTCR_RST_CFG;
			alarm_repeat_counter_q <= `RTCR_RST_CFG;
		end else begin
			if (wr && paddr == `RTCR_OFS_ALCFG) begin
				alcfg_q <= {wb[7:2], 2'h0};
			end else if (ev && alarm_repeat_counter_q == 8'h00 && !alcfg_q[`RTCR_B_CHIME]) begin
				alcfg_q[`RTCR_B_AEN] <= 1'b0;
			end
			if (wr && paddr == `RTCR_OFS_ALARM_REPEAT_COUNTER) begin
				alarm_repeat_counter_q <= wb;
			end else if (ev && (alarm_repeat_counter_q != 8'h00 || alcfg_q[`RTCR_B_CHIME])) begin
				alarm_repeat_counter_q <= alarm_repeat_counter_q - 8'h01;
			end
		end
	end

	// Alarm pulse lasts one half second; power control window from each second
	always_ff @(posedge mclk) begin
		if (rst) begin
			apulse_q <= 1'b0;
			pwc_q <= 16'h0000;
		end else begin
			if (ev) begin
				apulse_q <= 1'b1;
			end else if (half_end) begin
				apulse_q <= 1'b0;
			end
			if (sec_end) begin
				pwc_q <= 16'h0000;
			end else if (tick && pwc_q != 16'hffff) begin
				pwc_q <= pwc_q + 16'h0001;
			end
		end
	end

	// Output pin mux
	always_ff @(posedge mclk) begin
		if (rst) begin
			rtc_pin_q <= 1'b0;
			rtc_pin_oe_q <= 1'b0;
		end else begin
			rtc_pin_oe_q <= cfg1_q[`RTCR_B_OE];
			if (!cfg1_q[`RTCR_B_OE]) begin
				rtc_pin_q <= 1'b0;
			end else begin
				unique case (cfg2_q[1:0])
					2'h3: rtc_pin_q <= cfg2_q[`RTCR_B_PWPOL] ~^ (cfg2_q[`RTCR_B_PWEN] &&
						pwc_q < (`RTCR_PWC_STAB << cfg2_q[`RTCR_B_CPRE]) +
						(`RTCR_PWC_SAMP << cfg2_q[`RTCR_B_SPRE]));
					2'h2: rtc_pin_q <= s2_q[cfg2_q[3:2]];
					2'h1: rtc_pin_q <= half_q;
					2'h0: rtc_pin_q <= apulse_q;
				endcase
			end
		end
	end

	// Read mux
	always_comb begin
		unique case (paddr)
			`RTCR_OFS_CFG1: rbyte = {cfg1_q[7], 1'b0, cfg1_q[5], sync_q, half_q,
				cfg1_q[2], tptr};
			`RTCR_OFS_CAL: rbyte = cal_q;
			`RTCR_OFS_CFG2: rbyte = cfg2_q;
			`RTCR_OFS_ALCFG: rbyte = {alcfg_q[7:2], aptr};
			`RTCR_OFS_ALARM_REPEAT_COUNTER: rbyte = alarm_repeat_counter_q;
			`RTCR_OFS_TWH: rbyte = tptr == 2'h0 ? min_q : tptr == 2'h1 ? wd_q :
				tptr == 2'h2 ? mth_q : 8'h00;
			`RTCR_OFS_TWL: rbyte = tptr == 2'h0 ? sec_q : tptr == 2'h1 ? hr_q :
				tptr == 2'h2 ? day_q : yr_q;
			`RTCR_OFS_AWH: rbyte = aptr == 2'h0 ? amin_q : aptr == 2'h1 ? awd_q :
				aptr == 2'h2 ? amth_q : 8'h00;
			`RTCR_OFS_AWL: rbyte = aptr == 2'h0 ? asec_q : aptr == 2'h1 ? ahr_q :
				aptr == 2'h2 ? aday_q : 8'h00;
			default: rbyte = 8'h00;
		endcase
	end

	// APB slave: answer in the first access cycle, data latched at setup
	always_ff @(posedge mclk) begin
		if (rst || sys_rst) begin
			pready_q <= 1'b0;
			slverr_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_q <= 1'b1;
			slverr_q <= paddr > `RTCR_OFS_KEY || paddr[1:0] != 2'h0;
			rdata_q <= pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
		end else begin
			pready_q <= 1'b0;
			slverr_q <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || sys_rst);

	sequence s_twl_wr_locked;
		wr && paddr == `RTCR_OFS_TWL && !wren;
	endsequence
	sequence s_alarm_last;
		ev && alarm_repeat_counter_q == 8'h00 && !alcfg_q[`RTCR_B_CHIME] && !wr;
	endsequence

	property p_value_lock;
		s_twl_wr_locked |=> $stable(sec_q) || $past(sec_end);
	endproperty
	a_value_lock: assert property (p_value_lock) else $error("locked write changed value");
	property p_en_lock;
		wr && paddr == `RTCR_OFS_CFG1 && !wren |=> $stable(cfg1_q[`RTCR_B_EN]);
	endproperty
	a_en_lock: assert property (p_en_lock) else $error("enable changed while locked");
	property p_wren_key;
		wr && paddr == `RTCR_OFS_CFG1 && ul_q != RTCR_UL_ARMED |=> $stable(wren);
	endproperty
	a_wren_key: assert property (p_wren_key) else $error("write enable changed without key");
	property p_half_clr;
		wr && wren && paddr == `RTCR_OFS_TWL && tptr == 2'h0 |=> !half_q ##1 !half_q;
	endproperty
	a_half_clr: assert property (p_half_clr) else $error("half flag not cleared");
	property p_ptr_dec;
		(rd || wr) && paddr == `RTCR_OFS_TWH && tptr != 2'h0 |=> tptr == $past(tptr) - 2'h1;
	endproperty
	a_ptr_dec: assert property (p_ptr_dec) else $error("time pointer did not step");
	property p_rsvd_zero;
		psel && !penable && !pwrite && paddr == `RTCR_OFS_TWH && tptr == 2'h3 |=>
			prdata == 32'h0000_0000 && pready;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved slot not zero");
	property p_self_clear;
		s_alarm_last |=> !alcfg_q[`RTCR_B_AEN] && alarm_repeat_counter_q == 8'h00;
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("alarm did not self clear");
	property p_chime_wrap;
		ev && alarm_repeat_counter_q == 8'h00 && alcfg_q[`RTCR_B_CHIME] && !wr |=> alarm_repeat_counter_q == 8'hff;
	endproperty
	a_chime_wrap: assert property (p_chime_wrap) else $error("chime did not wrap");
	property p_oe_off;
		!cfg1_q[`RTCR_B_OE] [*2] |-> !rtc_pin_oe_q && !rtc_pin_q;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin active while disabled");
endmodule : rtcr_top

// [tb_top.sv]
// Self-checking testbench for the clock-calendar register layer
`include "rtcr_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcr_pkg::*;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sys_rst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] src_pins = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rtc_pin_q;
	logic rtc_pin_oe_q;
	logic src_run = 1'b0;
	logic [7:0] div_q = 8'h00;
	logic [15:0] lfsr_q = 16'hf7c9;
	logic [7:0] rv;
	logic ev;
	int fails = 0;
	int comparisons = 0;
	rtcr_byte_type lo [4];
	rtcr_byte_type hi [4];

	always #50 mclk = ~mclk;

	// Four source rates, each pin at half the rate of the pin below it, quiet until the timebase tests
	always @(posedge mclk) begin
		div_q <= div_q + 8'h01;
		src_pins <= src_run ? {div_q[5], div_q[4], div_q[3], div_q[2]} : 4'h0;
	end

	// Short half second keeps the alarm tests within a few thousand cycles
	rtcr_top #(.TICKS_XTAL(16'h0004), .TICKS_50HZ(16'h0019), .TICKS_60HZ(16'h001e)) dut_u (
		.mclk(mclk), .rst(rst), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_pins(src_pins), .rtc_pin_q(rtc_pin_q),
		.rtc_pin_oe_q(rtc_pin_oe_q)
	);

	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return lfsr_q[7:0];
	endfunction : rnd

	function automatic logic [7:0] bcd(input int n);
		return 8'((n / 10) * 16 + n % 10);
	endfunction : bcd

	task automatic results();
		$display("counts: comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			$display("ERROR %0t no pready", $time);
		end
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask : rd

	task automatic unlock(input logic [7:0] d);
		wr(`RTCR_OFS_KEY, `RTCR_KEY1);
		wr(`RTCR_OFS_KEY, `RTCR_KEY2);
		wr(`RTCR_OFS_CFG1, d);
	endtask : unlock

	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		results();
	end

	initial begin
		int seen1;
		int seen0;
		int sy;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(`RTCR_OFS_CFG1); chk(rv, 8'h00, "cfg1 reset");
		rd(`RTCR_OFS_CAL); chk(rv, 8'h00, "cal reset");
		rd(`RTCR_OFS_CFG2); chk(rv, 8'h00, "cfg2 reset");
		rd(`RTCR_OFS_ALCFG); chk(rv, 8'h00, "alarm cfg reset");
		rd(`RTCR_OFS_ALARM_REPEAT_COUNTER); chk(rv, 8'h00, "repeat reset");
		$display("test reset values done");
		wr(`RTCR_OFS_CFG2, 8'h5a);
		rd(`RTCR_OFS_CFG2); chk(rv, 8'h00, "locked cfg2");
		wr(`RTCR_OFS_CFG1, 8'ha0);
		rd(`RTCR_OFS_CFG1); chk(rv & 8'he7, 8'h00, "plain wren write");
		unlock(8'h20);
		rd(`RTCR_OFS_CFG1); chk(rv & 8'he7, 8'h20, "unlocked");
		wr(`RTCR_OFS_CFG1, 8'h84);
		rd(`RTCR_OFS_CFG1); chk(rv & 8'he7, 8'ha4, "enable and oe");
		chk({7'h0, rtc_pin_oe_q}, 8'h01, "oe on");
		wr(`RTCR_OFS_CFG1, 8'h00);
		repeat (2) @(posedge mclk);
		chk({6'h0, rtc_pin_oe_q, rtc_pin_q}, 8'h00, "oe off");
		for (int i = 0; i < 4; i++) begin
			lo[0] = rnd();
			wr(`RTCR_OFS_CAL, lo[0]);
			rd(`RTCR_OFS_CAL); chk(rv, lo[0], "cal");
			wr(`RTCR_OFS_CFG2, lo[0] ^ 8'h3c);
			rd(`RTCR_OFS_CFG2); chk(rv, lo[0] ^ 8'h3c, "cfg2");
		end
		wr(`RTCR_OFS_CAL, 8'h00);
		wr(`RTCR_OFS_CFG2, 8'h00);
		$display("test lock and config done");
		lo[3] = bcd(rnd() % 100); lo[2] = bcd(1 + rnd() % 28);
		lo[1] = bcd(rnd() % 24); lo[0] = bcd(rnd() % 60);
		hi[3] = 8'h00; hi[2] = bcd(1 + rnd() % 12);
		hi[1] = 8'(rnd() % 7); hi[0] = bcd(rnd() % 60);
		wr(`RTCR_OFS_CFG1, 8'h03);
		for (int p = 3; p >= 0; p--) begin
			wr(`RTCR_OFS_TWL, lo[p]);
			if (p == 3) begin
				rd(`RTCR_OFS_TWH); chk(rv, 8'h00, "reserved high");
			end else
				wr(`RTCR_OFS_TWH, hi[p]);
		end
		rd(`RTCR_OFS_TWH);
		rd(`RTCR_OFS_CFG1); chk(rv & 8'h03, 8'h00, "pointer stops");
		wr(`RTCR_OFS_CFG1, 8'h03);
		for (int p = 3; p >= 0; p--) begin
			rd(`RTCR_OFS_TWL); chk(rv, lo[p], "low window");
			rd(`RTCR_OFS_TWH); chk(rv, hi[p], "high window");
		end
		unlock(8'h03);
		wr(`RTCR_OFS_TWL, 8'h77);
		rd(`RTCR_OFS_TWL); chk(rv, lo[3], "locked window");
		unlock(8'h20);
		wr(`RTCR_OFS_ALCFG, 8'h03);
		rd(`RTCR_OFS_AWH); chk(rv, 8'h00, "alarm ptr 3 high");
		for (int p = 2; p >= 0; p--) begin
			wr(`RTCR_OFS_AWL, lo[p]);
			wr(`RTCR_OFS_AWH, hi[p]);
		end
		rd(`RTCR_OFS_ALCFG); chk(rv & 8'h03, 8'h00, "alarm ptr stops");
		wr(`RTCR_OFS_ALCFG, 8'h02);
		for (int p = 2; p >= 0; p--) begin
			rd(`RTCR_OFS_AWL); chk(rv, lo[p], "alarm low");
			rd(`RTCR_OFS_AWH); chk(rv, hi[p], "alarm high");
		end
		for (int m = 0; m < 10; m++) begin
			wr(`RTCR_OFS_ALCFG, 8'(m << 2));
			rd(`RTCR_OFS_ALCFG); chk(rv, 8'(m << 2), "mask code");
		end
		$display("test windows done");
		wr(`RTCR_OFS_CFG1, 8'ha0);
		src_run <= 1'b1;
		seen1 = 0;
		sy = 0;
		for (int i = 0; i < 200 && seen1 == 0; i++) begin
			rd(`RTCR_OFS_CFG1);
			seen1 = rv[3];
			sy = sy | rv[4];
		end
		chk(8'(seen1), 8'h01, "half flag rises");
		wr(`RTCR_OFS_TWL, 8'h00);
		rd(`RTCR_OFS_CFG1); chk({7'h0, rv[3]}, 8'h00, "half flag cleared");
		chk(8'(sy), 8'h01, "sync flag seen");
		wr(`RTCR_OFS_CFG2, 8'h02);
		wr(`RTCR_OFS_CFG1, 8'ha4);
		seen1 = 0;
		seen0 = 0;
		repeat (64) begin
			@(posedge mclk);
			if (rtc_pin_q === 1'b1) seen1++;
			if (rtc_pin_q === 1'b0) seen0++;
		end
		chk(8'((seen1 > 0) && (seen0 > 0)), 8'h01, "source clock on pin");
		// Power control off: pin rests at the inactive level of the polarity
		wr(`RTCR_OFS_CFG2, 8'h03);
		repeat (2) @(posedge mclk);
		chk({7'h0, rtc_pin_q}, 8'h01, "power idle, active low");
		wr(`RTCR_OFS_CFG2, 8'h43);
		repeat (2) @(posedge mclk);
		chk({7'h0, rtc_pin_q}, 8'h00, "power idle, active high");
		wr(`RTCR_OFS_CFG2, 8'h02);
		wr(`RTCR_OFS_CFG1, 8'ha0);
		repeat (3) @(posedge mclk);
		chk({7'h0, rtc_pin_q}, 8'h00, "pin off");
		$display("test timebase done");
		wr(`RTCR_OFS_ALARM_REPEAT_COUNTER, 8'h02);
		wr(`RTCR_OFS_ALCFG, 8'h80);
		rd(`RTCR_OFS_ALCFG);
		for (int i = 0; i < 400 && rv[7] !== 1'b0; i++)
			rd(`RTCR_OFS_ALCFG);
		chk({7'h0, rv[7]}, 8'h00, "alarm self clear");
		rd(`RTCR_OFS_ALARM_REPEAT_COUNTER); chk(rv, 8'h00, "repeat stops");
		wr(`RTCR_OFS_ALARM_REPEAT_COUNTER, 8'h01);
		wr(`RTCR_OFS_ALCFG, 8'hc0);
		for (int i = 0; i < 400 && rv !== 8'hff; i++)
			rd(`RTCR_OFS_ALARM_REPEAT_COUNTER);
		chk(rv, 8'hff, "chime wrap");
		rd(`RTCR_OFS_ALCFG); chk(rv & 8'hc0, 8'hc0, "chime keeps enable");
		wr(`RTCR_OFS_ALCFG, 8'h00);
		$display("test alarm done");
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rd(`RTCR_OFS_CFG1); chk(rv & 8'he7, 8'ha0, "cfg1 kept");
		rd(`RTCR_OFS_CFG2); chk(rv, 8'h02, "cfg2 kept");
		rd(8'h28); chk({ev, rv[6:0]}, 8'h80, "unmapped");
		rd(8'h02); chk({ev, rv[6:0]}, 8'h80, "unaligned");
		$display("test resets and errors done");
		results();
	end
endmodule : tb_top
